//--- rtl/qdf_pkg.sv
// Shared constants and types of the quad DAC serial frame decoder
package qdf_pkg;

    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS  = 12;
    localparam int NUM_CH     = 4;
    localparam int CNT_W      = 5;
    localparam int RANGE_W    = 3;
    localparam int CTRL_W     = 4;
    localparam int LEVEL_W    = 13;

    // Bit counter value of the final frame bit
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // Channel code position inside the data field
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 4;

    // Code values with a fixed meaning
    localparam logic [CODE_BITS-1:0] CODE_ZERO = 12'h000;
    localparam logic [CODE_BITS-1:0] CODE_MID  = 12'h800;

    // Control register bit positions and reset value
    localparam int CTRL_SDO_DIS = 0;
    localparam int CTRL_CLR_SEL = 1;
    localparam int CTRL_CLAMP   = 2;
    localparam int CTRL_TSD     = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h4;

    // Power control: writable bits and reset value
    localparam logic [15:0] PWR_WR_MASK = 16'h001F;
    localparam logic [15:0] PWR_RESET   = 16'h0000;

    localparam logic [RANGE_W-1:0] RANGE_RESET = 3'h0;
    localparam logic [FRAME_BITS-1:0] RD_RESET = 24'h000000;

    typedef struct packed {
        logic        rw;
        logic        zero;
        logic [2:0]  reg_sel;
        logic [2:0]  chan;
        logic [15:0] data;
    } qdf_frame_t;

    typedef enum logic [2:0] {
        QDF_REG_DAC   = 3'h0,
        QDF_REG_RANGE = 3'h1,
        QDF_REG_POWER = 3'h2,
        QDF_REG_CTRL  = 3'h3
    } qdf_reg_t;

    // Channel field values; codes 0..3 address one channel each
    localparam logic [2:0] QDF_CH_ALL = 3'h4;

    // Control register functions carried in the channel field
    typedef enum logic [2:0] {
        QDF_CTRL_NOP   = 3'h0,
        QDF_CTRL_CFG   = 3'h1,
        QDF_CTRL_CLEAR = 3'h4,
        QDF_CTRL_LOAD  = 3'h5
    } qdf_ctrl_fn_t;

    typedef enum logic [2:0] {
        QDF_UNI_5    = 3'h0,
        QDF_UNI_10   = 3'h1,
        QDF_UNI_10P8 = 3'h2,
        QDF_BIP_5    = 3'h3,
        QDF_BIP_10   = 3'h4,
        QDF_BIP_10P8 = 3'h5
    } qdf_range_t;

    typedef enum logic [1:0] {
        QDF_GAIN_2    = 2'h0,
        QDF_GAIN_4    = 2'h1,
        QDF_GAIN_4P32 = 2'h2
    } qdf_gain_t;

    typedef struct packed {
        logic                       bipolar;
        qdf_gain_t                  gain;
        logic signed [LEVEL_W-1:0]  level;
    } qdf_chout_t;

endpackage

//--- rtl/qdf_link.sv
// Serial link end: frame shifter and readback shifter on the link clock
`timescale 1ns/1ns
module qdf_link (
    input  wire logic                             sclk,
    input  wire logic                             resetn,
    input  wire logic                             sync_n,
    input  wire logic                             serial_data_in,
    input  wire logic [qdf_pkg::FRAME_BITS-1:0]   rd_word,
    output logic      [qdf_pkg::FRAME_BITS-1:0]   frame_word,
    output logic                                  frame_tgl,
    output logic                                  serial_data_out
);

    logic [qdf_pkg::CNT_W-1:0]      cnt_q;
    logic [qdf_pkg::FRAME_BITS-1:0] shift_q;
    logic [qdf_pkg::FRAME_BITS-1:0] shift_d;
    logic [qdf_pkg::FRAME_BITS-1:0] out_q;
    logic [qdf_pkg::FRAME_BITS-1:0] out_d;
    logic                           tgl_q;
    wire                            last_bit;
    wire                            first_bit;

    // New bit enters at the bottom so the first bit ends up on top
    assign shift_d   = {shift_q[qdf_pkg::FRAME_BITS-2:0], serial_data_in}; // R2
    assign last_bit  = (cnt_q == qdf_pkg::LAST_BIT);
    assign first_bit = (cnt_q == qdf_pkg::CNT_ZERO);
    // Readback word is taken whole at the first edge of a frame
    assign out_d = first_bit ? rd_word
                             : {out_q[qdf_pkg::FRAME_BITS-2:0], 1'b0};

    // Bit counter; the frame's own sync clears it, the clock may stop.
    // It parks one past the last bit so extra edges latch nothing.
    always_ff @(posedge sclk or posedge sync_n or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= qdf_pkg::CNT_ZERO;
        end else if (sync_n) begin
            cnt_q <= qdf_pkg::CNT_ZERO;
        end else if (cnt_q <= qdf_pkg::LAST_BIT) begin
            cnt_q <= cnt_q + 5'h01; // R1
        end
    end

    // Shift register, no reset needed: only whole frames are handed on
    always_ff @(posedge sclk) begin
        shift_q <= shift_d;
        if (last_bit && !sync_n) begin
            frame_word <= shift_d; // R1
        end
    end

    // Toggle and readback shifter; sclk may be idle in reset
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            tgl_q <= 1'b0;
            out_q <= qdf_pkg::RD_RESET;
        end else if (!sync_n) begin
            out_q <= out_d; // R2
            if (last_bit) begin
                tgl_q <= ~tgl_q;
            end
        end
    end

    assign frame_tgl       = tgl_q;
    assign serial_data_out = out_q[qdf_pkg::FRAME_BITS-1];

endmodule

//--- rtl/qdf_map.sv
// Code to output level mapping for one channel
`timescale 1ns/1ns
module qdf_map (
    input  wire logic                            clk,
    input  wire logic                            resetn,
    input  wire logic [qdf_pkg::CODE_BITS-1:0]   code,
    input  wire logic [qdf_pkg::RANGE_W-1:0]     range_sel,
    input  wire logic                            twos_comp,
    output qdf_pkg::qdf_chout_t                  ch_out
);

    qdf_pkg::qdf_chout_t out_d;
    wire                 bipolar;
    wire                 inv_msb;

    assign bipolar = (range_sel >= qdf_pkg::QDF_BIP_5);
    // Offset binary is twos complement with the top bit turned over
    assign inv_msb = code[qdf_pkg::CODE_BITS-1] ^ ~twos_comp;

    // Level is in LSB units: bipolar /2048, unipolar /4096 of gain*ref
    always_comb begin
        out_d.bipolar = bipolar;
        if (bipolar) begin
            out_d.level = $signed({inv_msb, inv_msb,
                                   code[qdf_pkg::CODE_BITS-2:0]}); // R9 R10
        end else begin
            out_d.level = $signed({1'b0, code}); // R11
        end
        case (range_sel)
            qdf_pkg::QDF_UNI_5,
            qdf_pkg::QDF_BIP_5:    out_d.gain = qdf_pkg::QDF_GAIN_2; // R12
            qdf_pkg::QDF_UNI_10,
            qdf_pkg::QDF_BIP_10:   out_d.gain = qdf_pkg::QDF_GAIN_4; // R12
            qdf_pkg::QDF_UNI_10P8,
            qdf_pkg::QDF_BIP_10P8: out_d.gain = qdf_pkg::QDF_GAIN_4P32; // R12
            default:               out_d.gain = qdf_pkg::QDF_GAIN_2;
        endcase
    end

    // Registered so the analog side sees a clean word
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ch_out <= '0;
        end else begin
            ch_out <= out_d;
        end
    end

endmodule

//--- rtl/qdf_top.sv
// Quad DAC serial frame decoder: link crossing, register file, mapping
//
// Overview of operation
// R1: A transfer is one 24-bit frame gathered in a shift register first.
// R2: Frame bits arrive most significant first and are shifted in so.
// R3: Bit 23 is read/write, 22 reserved, 21..19 register, 18..16 channel.
// R4: The host always sends the reserved bit 22 as zero.
// R5: The top bit picks a read of the addressed register or a write.
// R6: Register codes 000 data, 001 range, 010 power, 011 control.
// R7: Channel codes 000..011 pick A..D and 100 picks all four.
// R8: Every register can be written and read back.
// R9: Bipolar offset binary maps 800h to zero, all ones to +2047/2048.
// R10: Bipolar twos complement maps 0 to zero and 800h to most negative.
// R11: Unipolar ranges use straight binary, code/4096 times gain.
// R12: Gain is 2, 4 or 4.32 for the 5 V, 10 V and 10.8 V ranges.
// R13: The 12-bit code is data bits 15..4; bits 3..0 are ignored.
// R14: A coding pin chooses offset binary or twos complement.
`timescale 1ns/1ns
module qdf_top (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     sclk,
    input  wire logic                     sync_n,
    input  wire logic                     serial_data_in,
    input  wire logic                     coding_select_pin,
    output logic                          serial_data_out,
    output logic                          sdo_oe_n,
    output qdf_pkg::qdf_chout_t           ch_out [qdf_pkg::NUM_CH],
    output logic [qdf_pkg::NUM_CH-1:0]    ch_powered,
    output logic                          clamp_en,
    output logic                          tsd_en
);

    localparam int NCH = qdf_pkg::NUM_CH;
    localparam int CB  = qdf_pkg::CODE_BITS;
    localparam int RW  = qdf_pkg::RANGE_W;

    // Link side wires
    logic [qdf_pkg::FRAME_BITS-1:0] link_word;
    logic                           link_tgl;

    // Crossing and pin synchronisers
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_seen_q;
    logic cod_s1_q;
    logic cod_s2_q;

    // Register file
    logic [CB-1:0]             code_q  [NCH];
    logic [RW-1:0]             range_q [NCH];
    logic [qdf_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0]               power_q;
    logic [qdf_pkg::FRAME_BITS-1:0] rd_q;

    // Decode wires
    qdf_pkg::qdf_frame_t frame;
    wire                 frame_evt;
    wire                 do_write;
    wire                 do_read;
    wire                 sel_dac;
    wire                 sel_range;
    wire                 sel_power;
    wire                 sel_ctrl;
    wire                 ctrl_cfg;
    wire                 ctrl_clear;
    wire                 twos_comp;
    wire                 range_ok;
    wire [CB-1:0]        new_code;
    wire [RW-1:0]        new_range;
    wire [1:0]           rd_ch;
    logic [15:0]         rd_data;
    logic [NCH-1:0]      ch_hit;

    // Shifter and readback on the link's own clock
    qdf_link u_link (
        .sclk            (sclk),
        .resetn          (resetn),
        .sync_n          (sync_n),
        .serial_data_in  (serial_data_in),
        .rd_word         (rd_q),
        .frame_word      (link_word),
        .frame_tgl       (link_tgl),
        .serial_data_out (serial_data_out)
    );

    // Toggle crossing; the word it announces is held until the next
    // frame ends, so it is stable when the event is seen here
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tgl_s1_q   <= 1'b0;
            tgl_s2_q   <= 1'b0;
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_s1_q   <= link_tgl;
            tgl_s2_q   <= tgl_s1_q;
            tgl_seen_q <= tgl_s2_q;
        end
    end

    // Coding pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cod_s1_q <= 1'b1;
            cod_s2_q <= 1'b1;
        end else begin
            cod_s1_q <= coding_select_pin;
            cod_s2_q <= cod_s1_q;
        end
    end

    // Pin high selects offset binary, low twos complement
    assign twos_comp = ~cod_s2_q; // R14

    // Field split of the received frame
    assign frame     = qdf_pkg::qdf_frame_t'(link_word); // R3
    assign frame_evt = tgl_s2_q ^ tgl_seen_q;
    // Bit 22 is not checked; the host keeps it at zero
    assign do_write  = frame_evt & ~frame.rw; // R5 R4
    assign do_read   = frame_evt & frame.rw; // R5

    // Register select decode
    assign sel_dac   = (frame.reg_sel == qdf_pkg::QDF_REG_DAC); // R6
    assign sel_range = (frame.reg_sel == qdf_pkg::QDF_REG_RANGE); // R6
    assign sel_power = (frame.reg_sel == qdf_pkg::QDF_REG_POWER); // R6
    assign sel_ctrl  = (frame.reg_sel == qdf_pkg::QDF_REG_CTRL); // R6

    // Control functions ride in the channel field
    assign ctrl_cfg   = sel_ctrl & (frame.chan == qdf_pkg::QDF_CTRL_CFG);
    assign ctrl_clear = sel_ctrl & (frame.chan == qdf_pkg::QDF_CTRL_CLEAR);

    // Low four data bits are dropped for 12-bit channels
    assign new_code  = frame.data[qdf_pkg::CODE_MSB:qdf_pkg::CODE_LSB]; // R13
    assign new_range = frame.data[RW-1:0];
    // Unused range codes are refused so no channel gets an unknown gain
    assign range_ok  = (new_range <= qdf_pkg::QDF_BIP_10P8);

    // Readback of the all-channels code reports channel A
    assign rd_ch = (frame.chan == qdf_pkg::QDF_CH_ALL) ? 2'h0
                                                      : frame.chan[1:0];

    // Value a clear operation loads, per range and coding
    function automatic logic [CB-1:0] clr_code(
        input logic [RW-1:0] rng,
        input logic          twos,
        input logic          clr_sel
    );
        logic bip;
        bip = (rng >= qdf_pkg::QDF_BIP_5);
        if (!bip) begin
            clr_code = clr_sel ? qdf_pkg::CODE_MID : qdf_pkg::CODE_ZERO;
        end else if (clr_sel) begin
            // Negative full scale
            clr_code = twos ? qdf_pkg::CODE_MID : qdf_pkg::CODE_ZERO;
        end else begin
            // Zero volts
            clr_code = twos ? qdf_pkg::CODE_ZERO : qdf_pkg::CODE_MID;
        end
    endfunction

    // Per-channel data and range registers with their mappers
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            wire [2:0] my_addr;
            assign my_addr   = 3'(i);
            assign ch_hit[i] = (frame.chan == my_addr) |
                               (frame.chan == qdf_pkg::QDF_CH_ALL); // R7

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    code_q[i]  <= qdf_pkg::CODE_ZERO;
                    range_q[i] <= qdf_pkg::RANGE_RESET;
                end else if (do_write) begin
                    if (sel_dac && ch_hit[i]) begin
                        code_q[i] <= new_code; // R8
                    end else if (ctrl_clear) begin
                        code_q[i] <= clr_code(range_q[i], twos_comp,
                                        ctrl_q[qdf_pkg::CTRL_CLR_SEL]);
                    end
                    if (sel_range && ch_hit[i] && range_ok) begin
                        range_q[i] <= new_range; // R8
                    end
                end
            end

            qdf_map u_map (
                .clk       (clk),
                .resetn    (resetn),
                .code      (code_q[i]),
                .range_sel (range_q[i]),
                .twos_comp (twos_comp),
                .ch_out    (ch_out[i])
            );

            assign ch_powered[i] = power_q[i];
        end
    endgenerate

    // Control and power registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q  <= qdf_pkg::CTRL_RESET;
            power_q <= qdf_pkg::PWR_RESET;
        end else if (do_write) begin
            if (ctrl_cfg) begin
                ctrl_q <= frame.data[qdf_pkg::CTRL_W-1:0]; // R8
            end
            if (sel_power) begin
                power_q <= frame.data & qdf_pkg::PWR_WR_MASK; // R8
            end
        end
    end

    // Readback data selection for the addressed register
    always_comb begin
        rd_data = 16'h0000;
        case (frame.reg_sel)
            qdf_pkg::QDF_REG_DAC: begin
                rd_data = {code_q[rd_ch], 4'h0}; // R8
            end
            qdf_pkg::QDF_REG_RANGE: begin
                rd_data = {13'h0000, range_q[rd_ch]}; // R8
            end
            qdf_pkg::QDF_REG_POWER: begin
                rd_data = power_q; // R8
            end
            qdf_pkg::QDF_REG_CTRL: begin
                if (frame.chan == qdf_pkg::QDF_CTRL_CFG) begin
                    rd_data = {12'h000, ctrl_q}; // R8
                end
            end
            default: begin
                rd_data = 16'h0000;
            end
        endcase
    end

    // Readback word goes out during the next frame
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_q <= qdf_pkg::RD_RESET;
        end else if (do_read) begin
            rd_q <= {frame.rw, frame.zero, frame.reg_sel, frame.chan,
                     rd_data}; // R5
        end
    end

    // Static control outputs straight from the register
    assign sdo_oe_n = ctrl_q[qdf_pkg::CTRL_SDO_DIS];
    assign clamp_en = ctrl_q[qdf_pkg::CTRL_CLAMP];
    assign tsd_en   = ctrl_q[qdf_pkg::CTRL_TSD];

endmodule

//--- sim/qdf_top_monitor.sv
// Port-level assertions for the quad DAC frame decoder
`timescale 1ns/1ns
module qdf_top_monitor (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 sclk,
    input wire logic                 sync_n,
    input wire logic                 serial_data_in,
    input wire logic                 coding_select_pin,
    input wire logic                 serial_data_out,
    input wire logic                 sdo_oe_n,
    input qdf_pkg::qdf_chout_t       ch_out [qdf_pkg::NUM_CH],
    input wire logic [3:0]           ch_powered,
    input wire logic                 clamp_en,
    input wire logic                 tsd_en
);
    logic [3:0] idle_q;
    logic [3:0] idle_d;

    // Clocks since select rose; register effects may only land soon after
    assign idle_d = !sync_n ? 4'h0 : (idle_q == 4'hF ? idle_q : idle_q + 4'h1);
    always_ff @(posedge clk) begin
        if (!resetn)
            idle_q <= 4'hF;
        else
            idle_q <= idle_d;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_RST_CTRL: assert property (
        $rose(resetn) |-> clamp_en && !tsd_en && !sdo_oe_n && ch_powered == 4'h0)
        else $error("control outputs not at reset values");
    AST_RST_CH: assert property (
        $rose(resetn) |-> {ch_out[0], ch_out[1], ch_out[2], ch_out[3]} == '0)
        else $error("channel outputs not cleared by reset");
    AST_CTRL_LATE: assert property (
        $changed({clamp_en, tsd_en, sdo_oe_n}) |-> idle_q inside {[1:3]})
        else $error("control bits changed outside a frame completion");
    AST_PWR_LATE: assert property (
        $changed(ch_powered) |-> idle_q inside {[1:3]})
        else $error("power bits changed outside a frame completion");
    AST_CH_LATE: assert property (
        $changed({ch_out[1].bipolar, ch_out[1].gain}) |-> idle_q inside {[2:4]})
        else $error("channel range changed outside a frame completion");
    AST_UNI_SPAN: assert property (
        !ch_out[2].bipolar |-> !ch_out[2].level[12])
        else $error("unipolar level went negative");
    AST_GAIN_CODE: assert property (
        ch_out[3].gain != 2'h3)
        else $error("undefined gain code");
    AST_PIN_SHIFT: assert property (
        $changed(ch_out[0].level) && idle_q > 4'h6 |-> ch_out[0].bipolar &&
        ((ch_out[0].level - $past(ch_out[0].level))
            inside {13'h0800, 13'h1800}))
        else $error("coding change gave wrong level step");
endmodule

//--- sim/qdf_host_model.sv
// Host serial port model that sends frames and collects readback
`timescale 1ns/1ns
module qdf_host_model (
    output logic      sclk,
    output logic      sync_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    // Idle: link clock parked low, select high
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // One frame MSB first; fewer than 24 bits cuts it short on purpose
    task automatic xfer(input logic [23:0] w, input int nb,
                        output logic [23:0] r);
        r = 24'h000000;
        sync_n = 1'b0;
        for (int i = 23; i > 23 - nb; i--) begin
            serial_data_in = w[i];
            #3 sclk = 1'b1;
            #3 r[i] = serial_data_out;
            sclk = 1'b0;
        end
        #3 sync_n = 1'b1;
        // Released line must not keep the last bit
        serial_data_in = ~serial_data_in;
    endtask
endmodule

//--- sim/test_qdf_top.sv
// Self-checking bench for the quad DAC frame decoder
`timescale 1ns/1ns
module test_qdf_top;
    logic                clk;
    logic                resetn;
    logic                coding_select_pin;
    wire                 sclk;
    wire                 sync_n;
    wire                 serial_data_in;
    logic                serial_data_out;
    logic                sdo_oe_n;
    qdf_pkg::qdf_chout_t ch_out [qdf_pkg::NUM_CH];
    logic [3:0]          ch_powered;
    logic                clamp_en;
    logic                tsd_en;
    logic [23:0]         rx;
    logic [23:0]         flg;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  cycles = 0;
    localparam logic [11:0] CODES [4] = '{12'h123, 12'h456, 12'h9AB, 12'hFED};
    localparam logic [11:0] TBL [3] = '{12'h000, 12'h800, 12'hFFF};

    assign flg = {17'h0, sdo_oe_n, clamp_en, tsd_en, ch_powered};

    qdf_top i_qdf_top (.clk(clk), .resetn(resetn), .sclk(sclk),
        .sync_n(sync_n), .serial_data_in(serial_data_in),
        .coding_select_pin(coding_select_pin),
        .serial_data_out(serial_data_out), .sdo_oe_n(sdo_oe_n),
        .ch_out(ch_out), .ch_powered(ch_powered), .clamp_en(clamp_en),
        .tsd_en(tsd_en));
    qdf_host_model i_qdf_host_model (.sclk(sclk), .sync_n(sync_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string n, input logic [23:0] e,
                            input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_ch(input int i, input logic b, input logic [1:0] gn,
                          input logic [12:0] l);
        num_checks++;
        if (ch_out[i] !== {b, gn, l}) begin
            fail_count++;
            $display("unexpected ch_out%0d exp %h got %h", i, {b, gn, l},
                     ch_out[i]);
        end
    endtask

    // Whole frame, then a gap long enough for the crossing to settle
    task automatic send(input logic [23:0] w);
        i_qdf_host_model.xfer(w, 24, rx);
        repeat (8) @(negedge clk);
    endtask

    task automatic wr(input logic [2:0] rg, input logic [2:0] ch,
                      input logic [15:0] d);
        send({2'b00, rg, ch, d});
    endtask

    // Read frame, then a no-op frame that shifts the answer out
    task automatic rd(input logic [2:0] rg, input logic [2:0] ch,
                      input logic [15:0] e);
        send({2'b10, rg, ch, 16'h0000});
        send(24'h180000);
        chk_word("readback", {2'b10, rg, ch, e}, rx);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard: the sequence needs well under 3000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected timeout exp done got hang");
            wrap_up();
        end
    end

    initial begin
        // Start high for a moment so the link's async clear sees an edge
        resetn = 1'b1;
        coding_select_pin = 1'b0;
        #1 resetn = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        chk_word("flags", 24'h000020, flg);
        for (int i = 0; i < 4; i++) chk_ch(i, 1'b0, 2'h0, 13'h0000);
        // One channel at a time, then all; low data nibble is junk
        for (int c = 0; c < 4; c++) begin
            wr(3'h0, c[2:0], {CODES[c], 4'hF});
            for (int j = 0; j < 4; j++)
                chk_ch(j, 1'b0, 2'h0, j <= c ? {1'b0, CODES[j]} : 13'h0);
        end
        wr(3'h0, 3'h4, 16'hFFF0);
        for (int j = 0; j < 4; j++) chk_ch(j, 1'b0, 2'h0, 13'h0FFF);
        // Every range on channel A at full code
        for (int r = 0; r < 6; r++) begin
            wr(3'h1, 3'h0, {13'h0000, r[2:0]});
            chk_ch(0, r > 2, 2'(r % 3), r > 2 ? 13'h1FFF : 13'h0FFF);
        end
        wr(3'h1, 3'h0, 16'h0006);
        chk_ch(0, 1'b1, 2'h2, 13'h1FFF);
        // Both codings at the landmark codes
        for (int k = 0; k < 3; k++) begin
            wr(3'h0, 3'h0, {TBL[k], 4'h0});
            for (int p = 0; p < 2; p++) begin
                coding_select_pin = p[0];
                repeat (6) @(negedge clk);
                chk_ch(0, 1'b1, 2'h2, p == 1 ? {1'b0, TBL[k]} - 13'h0800
                       : {TBL[k][11], TBL[k]});
            end
        end
        chk_ch(1, 1'b0, 2'h0, 13'h0FFF);
        rd(3'h0, 3'h1, 16'hFFF0);
        rd(3'h1, 3'h0, 16'h0005);
        wr(3'h2, 3'h0, 16'hFFFA);
        chk_word("flags", 24'h00002A, flg);
        rd(3'h2, 3'h0, 16'h001A);
        wr(3'h3, 3'h1, 16'h000A);
        chk_word("flags", 24'h00001A, flg);
        rd(3'h3, 3'h1, 16'h000A);
        wr(3'h3, 3'h1, 16'h0005);
        chk_word("flags", 24'h00006A, flg);
        wr(3'h3, 3'h1, 16'h0004);
        // Clear with select 0 gives 0 V, select 1 low end or midscale
        wr(3'h3, 3'h4, 16'h0000);
        chk_ch(0, 1'b1, 2'h2, 13'h0000);
        chk_ch(1, 1'b0, 2'h0, 13'h0000);
        wr(3'h3, 3'h1, 16'h0006);
        wr(3'h3, 3'h4, 16'h0000);
        chk_ch(0, 1'b1, 2'h2, 13'h1800);
        chk_ch(1, 1'b0, 2'h0, 13'h0800);
        // A frame one bit short must be dropped
        i_qdf_host_model.xfer(24'h100000, 23, rx);
        repeat (8) @(negedge clk);
        chk_word("flags", 24'h00002A, flg);
        wrap_up();
    end
endmodule

bind qdf_top qdf_top_monitor i_qdf_top_monitor (.clk(clk), .resetn(resetn),
    .sclk(sclk), .sync_n(sync_n), .serial_data_in(serial_data_in),
    .coding_select_pin(coding_select_pin),
    .serial_data_out(serial_data_out), .sdo_oe_n(sdo_oe_n),
    .ch_out(ch_out), .ch_powered(ch_powered), .clamp_en(clamp_en),
    .tsd_en(tsd_en));
